// *** rtl/sgfc_pkg.sv ***
package sgfc_pkg;

    // register addresses on the management interface
    localparam logic [7:0] SGFC_ADDR_GC_ZERO = 8'h02;
    localparam logic [7:0] SGFC_ADDR_GC_ONE = 8'h03;

    // field positions in global_control_zero
    localparam int SGFC_GC0_CONF_DROP = 1;
    localparam int SGFC_GC0_LINK_FAST_AGE = 0;

    // field positions in global_control_one
    localparam int SGFC_GC1_PASS_ALL = 7;
    localparam int SGFC_GC1_RSVD6 = 6;
    localparam int SGFC_GC1_TX_PAUSE_DIS = 5;
    localparam int SGFC_GC1_RX_PAUSE_DIS = 4;
    localparam int SGFC_GC1_LEN_CHECK = 3;
    localparam int SGFC_GC1_AGING_EN = 2;
    localparam int SGFC_GC1_FAST_AGE_EN = 1;

    // fixed reset values of the bits that have no strap
    localparam logic SGFC_RST_CONF_DROP = 1'h0;
    localparam logic SGFC_RST_LINK_FAST_AGE = 1'h0;
    localparam logic SGFC_RST_PASS_ALL = 1'h0;
    localparam logic SGFC_RST_RSVD6 = 1'h0;
    localparam logic SGFC_RST_LEN_CHECK = 1'h0;
    localparam logic SGFC_RST_FAST_AGE_EN = 1'h0;
    // pull levels of the straps, held until the strap is sampled
    localparam logic SGFC_PULL_PAUSE = 1'h0;
    localparam logic SGFC_PULL_AGING = 1'h1;

    // frame classification constants
    localparam logic [15:0] SGFC_TYPE_MAC_CTRL = 16'h8808;
    localparam logic [47:0] SGFC_DA_PAUSE = 48'h0180C2000001;
    localparam logic [15:0] SGFC_LEN_LIMIT = 16'h05DC;

    // timing
    localparam int SGFC_CLK_KHZ = 40000;
    localparam int SGFC_FAST_AGE_US = 800;
    // longest time, rounded down to whole cycles
    localparam int SGFC_FAST_AGE_CYCLES = (SGFC_FAST_AGE_US * SGFC_CLK_KHZ) / 1000;
    localparam int SGFC_NORMAL_AGE_CYCLES = 1000000;
    localparam int SGFC_STRAP_SYNC_CYCLES = 2;

    localparam int SGFC_NUM_PORTS = 5;

    // one management access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sgfc_mgmt_req_type;

    // header facts about one received frame, from the receive MAC
    typedef struct packed {
        logic valid;
        logic [47:0] da;
        logic [15:0] type_len;
        logic [15:0] payload_len;
        logic flow_class;
        logic bad;
    } sgfc_frame_info_type;

    // filtering verdict for one frame
    typedef struct packed {
        logic valid;
        logic drop;
        logic ctrl_hit;
        logic len_hit;
        logic err_hit;
    } sgfc_verdict_type;

endpackage

// *** rtl/sgfc_tick_gen.sv ***
// periodic one-cycle tick with a run-time period and a restart
module sgfc_tick_gen #(
    parameter int WIDTH = 24
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic i_restart,
    input wire logic [WIDTH-1:0] i_period,
    output logic o_tick
);
    import sgfc_pkg::*;

    logic [WIDTH-1:0] count; // cycles left to the next tick
    logic [WIDTH-1:0] next_count;
    logic tick;
    logic next_tick;

    // count down; a restart or a disable reloads so a new period starts clean
    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (!i_enable || i_restart) begin
            next_count = i_period - WIDTH'(1);
        end else if (count == '0) begin
            next_tick = 1'b1;
            next_count = i_period - WIDTH'(1);
        end else begin
            next_count = count - WIDTH'(1);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end

    assign o_tick = tick;

    initial begin
        if (WIDTH < 2) begin
            $error("sgfc_tick_gen width too small");
        end
    end
endmodule // sgfc_tick_gen

// *** rtl/sgfc_top.sv ***
// Function
// - conformance mode drops MAC-control type or pause DA
// - conformance clear drops flow-class frames instead of MAC-control type or pause DA
// - link loss with bit set fast-ages quickly
// - pass-all forwards every frame, errored included
// - transmit pause follows autoneg unless disabled
// - receive pause follows autoneg unless disabled
// - one strap sets both pause disables
// - length check drops short mismatched frames
// - aging enable bit, strap default enabled
// - fast age enable uses 800us period
module sgfc_top
    import sgfc_pkg::*;
#(
    parameter int FAST_AGE_CYCLES = sgfc_pkg::SGFC_FAST_AGE_CYCLES,
    parameter int NORMAL_AGE_CYCLES = sgfc_pkg::SGFC_NORMAL_AGE_CYCLES,
    parameter int NUM_PORTS = sgfc_pkg::SGFC_NUM_PORTS
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire sgfc_pkg::sgfc_mgmt_req_type i_mgmt_req,
    output logic [7:0] o_mgmt_rdata,
    output logic o_mgmt_rvalid,
    input wire logic i_pause_strap_pin,
    input wire logic i_aging_strap_pin,
    input wire sgfc_pkg::sgfc_frame_info_type i_frame,
    output sgfc_pkg::sgfc_verdict_type o_verdict,
    input wire logic i_an_tx_pause,
    input wire logic i_an_rx_pause,
    output logic o_tx_pause_en,
    output logic o_rx_pause_en,
    input wire logic [NUM_PORTS-1:0] i_link_up,
    output logic [NUM_PORTS-1:0] o_flush_ports,
    output logic o_age_enable,
    output logic o_age_tick
);
    import sgfc_pkg::*;

    localparam int TW = $clog2(NORMAL_AGE_CYCLES + FAST_AGE_CYCLES + 1) + 1;

    // ---------------------------------------------------------------
    // control bits
    // ---------------------------------------------------------------
    logic conformance_drop_mode; // gc0 bit 1
    logic link_fast_age; // gc0 bit 0
    logic pass_all; // gc1 bit 7
    logic rsvd6; // gc1 bit 6, plain storage
    logic tx_pause_dis; // gc1 bit 5
    logic rx_pause_dis; // gc1 bit 4
    logic len_check; // gc1 bit 3
    logic aging_en; // gc1 bit 2
    logic fast_age_en; // gc1 bit 1
    logic next_conformance_drop_mode;
    logic next_link_fast_age;
    logic next_pass_all;
    logic next_rsvd6;
    logic next_tx_pause_dis;
    logic next_rx_pause_dis;
    logic next_len_check;
    logic next_aging_en;
    logic next_fast_age_en;

    // strap synchronisers; the first stage feeds only the second
    logic pause_strap_s1;
    logic pause_strap_s2;
    logic aging_strap_s1;
    logic aging_strap_s2;

    // strap sampling after reset release
    logic [1:0] strap_wait; // cycles counted up after release until the synchronisers are settled
    logic [1:0] next_strap_wait;
    logic strap_done; // straps have been taken into the register
    logic next_strap_done;
    logic strap_load;

    // read path
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    logic [7:0] gc0_view;
    logic [7:0] gc1_view;

    // strap synchronisers run every cycle, no logic between the stages
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pause_strap_s1 <= SGFC_PULL_PAUSE;
            pause_strap_s2 <= SGFC_PULL_PAUSE;
            aging_strap_s1 <= SGFC_PULL_AGING;
            aging_strap_s2 <= SGFC_PULL_AGING;
        end else begin
            pause_strap_s1 <= i_pause_strap_pin;
            pause_strap_s2 <= pause_strap_s1;
            aging_strap_s1 <= i_aging_strap_pin;
            aging_strap_s2 <= aging_strap_s1;
        end
    end

    // wait until the second stage holds a pin level taken after release
    always_comb begin
        next_strap_wait = strap_wait;
        next_strap_done = strap_done;
        strap_load = 1'b0;
        if (!strap_done) begin
            if (strap_wait == 2'(SGFC_STRAP_SYNC_CYCLES)) begin
                strap_load = 1'b1;
                next_strap_done = 1'b1;
            end else begin
                next_strap_wait = strap_wait + 2'h1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            strap_wait <= 2'h0;
            strap_done <= 1'b0;
        end else begin
            strap_wait <= next_strap_wait;
            strap_done <= next_strap_done;
        end
    end

    // register writes; the strap load wins over a write in the same cycle,
    // which the host avoids by waiting for the documented settle time
    always_comb begin
        next_conformance_drop_mode = conformance_drop_mode;
        next_link_fast_age = link_fast_age;
        next_pass_all = pass_all;
        next_rsvd6 = rsvd6;
        next_tx_pause_dis = tx_pause_dis;
        next_rx_pause_dis = rx_pause_dis;
        next_len_check = len_check;
        next_aging_en = aging_en;
        next_fast_age_en = fast_age_en;
        if (strap_load) begin
            // one pin gives both pause defaults
            next_tx_pause_dis = pause_strap_s2;
            next_rx_pause_dis = pause_strap_s2;
            next_aging_en = aging_strap_s2;
        end else if (i_mgmt_req.wr) begin
            if (i_mgmt_req.addr == SGFC_ADDR_GC_ZERO) begin
                // other gc0 bits belong to neighbouring logic
                next_conformance_drop_mode = i_mgmt_req.wdata[SGFC_GC0_CONF_DROP];
                next_link_fast_age = i_mgmt_req.wdata[SGFC_GC0_LINK_FAST_AGE];
            end else if (i_mgmt_req.addr == SGFC_ADDR_GC_ONE) begin
                next_pass_all = i_mgmt_req.wdata[SGFC_GC1_PASS_ALL];
                next_rsvd6 = i_mgmt_req.wdata[SGFC_GC1_RSVD6];
                // each pause bit is written on its own after the strap
                next_tx_pause_dis = i_mgmt_req.wdata[SGFC_GC1_TX_PAUSE_DIS];
                next_rx_pause_dis = i_mgmt_req.wdata[SGFC_GC1_RX_PAUSE_DIS];
                next_len_check = i_mgmt_req.wdata[SGFC_GC1_LEN_CHECK];
                next_aging_en = i_mgmt_req.wdata[SGFC_GC1_AGING_EN];
                next_fast_age_en = i_mgmt_req.wdata[SGFC_GC1_FAST_AGE_EN];
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            conformance_drop_mode <= SGFC_RST_CONF_DROP;
            link_fast_age <= SGFC_RST_LINK_FAST_AGE;
            pass_all <= SGFC_RST_PASS_ALL;
            rsvd6 <= SGFC_RST_RSVD6;
            tx_pause_dis <= SGFC_PULL_PAUSE;
            rx_pause_dis <= SGFC_PULL_PAUSE;
            len_check <= SGFC_RST_LEN_CHECK;
            aging_en <= SGFC_PULL_AGING;
            fast_age_en <= SGFC_RST_FAST_AGE_EN;
        end else begin
            conformance_drop_mode <= next_conformance_drop_mode;
            link_fast_age <= next_link_fast_age;
            pass_all <= next_pass_all;
            rsvd6 <= next_rsvd6;
            tx_pause_dis <= next_tx_pause_dis;
            rx_pause_dis <= next_rx_pause_dis;
            len_check <= next_len_check;
            aging_en <= next_aging_en;
            fast_age_en <= next_fast_age_en;
        end
    end

    // register views; bits not held here read as zero
    always_comb begin
        gc0_view = 8'h00;
        gc0_view[SGFC_GC0_CONF_DROP] = conformance_drop_mode;
        gc0_view[SGFC_GC0_LINK_FAST_AGE] = link_fast_age;
        gc1_view = 8'h00;
        gc1_view[SGFC_GC1_PASS_ALL] = pass_all;
        gc1_view[SGFC_GC1_RSVD6] = rsvd6;
        gc1_view[SGFC_GC1_TX_PAUSE_DIS] = tx_pause_dis;
        gc1_view[SGFC_GC1_RX_PAUSE_DIS] = rx_pause_dis;
        gc1_view[SGFC_GC1_LEN_CHECK] = len_check;
        gc1_view[SGFC_GC1_AGING_EN] = aging_en;
        gc1_view[SGFC_GC1_FAST_AGE_EN] = fast_age_en;
    end

    // read answer one cycle after the request; other addresses read zero
    always_comb begin
        next_rvalid = i_mgmt_req.rd;
        next_rdata = rdata;
        if (i_mgmt_req.rd) begin
            if (i_mgmt_req.addr == SGFC_ADDR_GC_ZERO) begin
                next_rdata = gc0_view;
            end else if (i_mgmt_req.addr == SGFC_ADDR_GC_ONE) begin
                next_rdata = gc1_view;
            end else begin
                next_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    assign o_mgmt_rdata = rdata;
    assign o_mgmt_rvalid = rvalid;

    // ---------------------------------------------------------------
    // frame filter: reads the live bits, so a write applies to the
    // next frame presented without any restart
    // ---------------------------------------------------------------
    sgfc_verdict_type verdict;
    sgfc_verdict_type next_verdict;
    logic ctrl_hit;
    logic len_hit;

    always_comb begin
        if (conformance_drop_mode) begin
            ctrl_hit = (i_frame.type_len == SGFC_TYPE_MAC_CTRL)
                || (i_frame.da == SGFC_DA_PAUSE);
        end else begin
            ctrl_hit = i_frame.flow_class;
        end
        // only 802.3 length values below the limit are checked
        len_hit = len_check && (i_frame.type_len < SGFC_LEN_LIMIT)
            && (i_frame.type_len != i_frame.payload_len);
        next_verdict.valid = i_frame.valid;
        next_verdict.ctrl_hit = ctrl_hit;
        next_verdict.len_hit = len_hit;
        next_verdict.err_hit = i_frame.bad;
        // pass-all is a debug override and beats every filter
        if (pass_all) begin
            next_verdict.drop = 1'b0;
        end else begin
            next_verdict.drop = ctrl_hit || len_hit || i_frame.bad;
        end
        if (!i_frame.valid) begin
            next_verdict = '0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            verdict <= '0;
        end else begin
            verdict <= next_verdict;
        end
    end

    assign o_verdict = verdict;

    // pause enables follow autonegotiation unless disabled
    assign o_tx_pause_en = i_an_tx_pause && !tx_pause_dis;
    assign o_rx_pause_en = i_an_rx_pause && !rx_pause_dis;

    // ---------------------------------------------------------------
    // aging: link-loss flush and the age tick
    // ---------------------------------------------------------------
    logic [NUM_PORTS-1:0] link_q; // link state seen last cycle
    logic [NUM_PORTS-1:0] flush;
    logic [NUM_PORTS-1:0] next_flush;
    logic [TW-1:0] age_period;
    logic tick;

    // a falling link with the bit set asks the table to flush that port
    // in the next cycle, far inside the fast-age bound
    always_comb begin
        next_flush = '0;
        if (link_fast_age) begin
            next_flush = link_q & ~i_link_up;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            link_q <= '0;
            flush <= '0;
        end else begin
            link_q <= i_link_up;
            flush <= next_flush;
        end
    end

    assign o_flush_ports = flush;

    // fast period replaces the normal one when fast age is on; the coming
    // value is used so the restart already loads the new period
    assign age_period = next_fast_age_en ? TW'(FAST_AGE_CYCLES)
        : TW'(NORMAL_AGE_CYCLES);

    // a change of period restarts the count so it never runs long
    sgfc_tick_gen #(
        .WIDTH(TW)
    ) u_age_tick (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_enable(aging_en),
        .i_restart(fast_age_en != next_fast_age_en),
        .i_period(age_period),
        .o_tick(tick)
    );

    assign o_age_tick = tick;
    assign o_age_enable = aging_en;

    initial begin
        if (FAST_AGE_CYCLES < 2 || NORMAL_AGE_CYCLES < 2 || NUM_PORTS < 1) begin
            $error("sgfc_top parameters out of range");
        end
    end
endmodule // sgfc_top

// *** test/sgfc_checker.sv ***
// watches the top ports; all relations in the core clock domain
module sgfc_checker
    import sgfc_pkg::*;
#(
    parameter int NUM_PORTS = 5
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire sgfc_pkg::sgfc_mgmt_req_type i_mgmt_req,
    input wire logic o_mgmt_rvalid,
    input wire sgfc_pkg::sgfc_frame_info_type i_frame,
    input wire sgfc_pkg::sgfc_verdict_type o_verdict,
    input wire logic i_an_tx_pause,
    input wire logic i_an_rx_pause,
    input wire logic o_tx_pause_en,
    input wire logic o_rx_pause_en,
    input wire logic [NUM_PORTS-1:0] i_link_up,
    input wire logic [NUM_PORTS-1:0] o_flush_ports,
    input wire logic o_age_enable,
    input wire logic o_age_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    // a write to the second register, used by the pause gates
    wire logic gc1_wr = i_mgmt_req.wr && (i_mgmt_req.addr == SGFC_ADDR_GC_ONE);

    a_read_answer: assert property (i_mgmt_req.rd |=> o_mgmt_rvalid)
        else $error("read got no answer pulse");
    a_verdict_follows: assert property (i_frame.valid |=> o_verdict.valid)
        else $error("frame got no verdict");
    a_tx_disable: assert property (gc1_wr && i_mgmt_req.wdata[SGFC_GC1_TX_PAUSE_DIS] |=>
        !o_tx_pause_en)
        else $error("tx pause on after disable write");
    a_rx_disable: assert property (gc1_wr && i_mgmt_req.wdata[SGFC_GC1_RX_PAUSE_DIS] |=>
        !o_rx_pause_en)
        else $error("rx pause on after disable write");
    a_tx_follow_an: assert property (o_tx_pause_en |-> i_an_tx_pause)
        else $error("tx pause on without autoneg");
    a_rx_follow_an: assert property (o_rx_pause_en |-> i_an_rx_pause)
        else $error("rx pause on without autoneg");
    a_drop_cause: assert property (o_verdict.drop |->
        (o_verdict.ctrl_hit || o_verdict.len_hit || o_verdict.err_hit))
        else $error("drop without cause");
    a_len_cause: assert property (o_verdict.len_hit |->
        $past(i_frame.type_len) < SGFC_LEN_LIMIT
        && $past(i_frame.type_len) != $past(i_frame.payload_len))
        else $error("length hit without mismatch");
    a_ctrl_cause: assert property (o_verdict.ctrl_hit && !$past(i_frame.flow_class) |->
        $past(i_frame.type_len) == SGFC_TYPE_MAC_CTRL || $past(i_frame.da) == SGFC_DA_PAUSE)
        else $error("control hit without match");
    a_flush_edge: assert property (|o_flush_ports |->
        (o_flush_ports & ~($past(i_link_up, 2) & ~$past(i_link_up))) == '0)
        else $error("flush without link fall");
    a_tick_gated: assert property (o_age_tick |-> o_age_enable)
        else $error("age tick while aging off");
    a_tick_spacing: assert property (o_age_tick |=> !o_age_tick [*8])
        else $error("age ticks too close");

    c_drop: cover property (o_verdict.drop);
    c_flush: cover property (|o_flush_ports);
    c_tick: cover property (o_age_tick);
endmodule // sgfc_checker

bind sgfc_top sgfc_checker #(.NUM_PORTS(NUM_PORTS)) sgfc_checker_inst (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_mgmt_req(i_mgmt_req),
    .o_mgmt_rvalid(o_mgmt_rvalid), .i_frame(i_frame), .o_verdict(o_verdict),
    .i_an_tx_pause(i_an_tx_pause), .i_an_rx_pause(i_an_rx_pause),
    .o_tx_pause_en(o_tx_pause_en),
    .o_rx_pause_en(o_rx_pause_en), .i_link_up(i_link_up), .o_flush_ports(o_flush_ports),
    .o_age_enable(o_age_enable), .o_age_tick(o_age_tick));

// *** test/sgfc_host_model.sv ***
// host side of the management port: single byte reads and writes
module sgfc_host_model (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output sgfc_pkg::sgfc_mgmt_req_type o_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import sgfc_pkg::*;

    initial o_req = '0;

    // request held one cycle, then released to idle
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        o_req <= '{1'h1, 1'h0, a, d};
        @(posedge i_ref_clk);
        o_req <= '0;
        #1;
    endtask

    // data taken at the edge where the answer pulse is high
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_ref_clk);
        o_req <= '{1'h0, 1'h1, a, 8'h00};
        @(posedge i_ref_clk);
        o_req <= '0;
        @(posedge i_ref_clk);
        // no answer pulse gives an unknown so the compare fails
        d = (i_rvalid === 1'h1) ? i_rdata : 8'hXX;
        #1;
    endtask
endmodule // sgfc_host_model

// *** test/tb_top.sv ***
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sgfc_pkg::*;

    logic i_ref_clk = 1'h0;
    logic i_resetn = 1'h0;
    sgfc_mgmt_req_type i_mgmt_req;
    logic [7:0] o_mgmt_rdata;
    logic o_mgmt_rvalid;
    logic i_pause_strap_pin = 1'h1; // non-default straps show the load
    logic i_aging_strap_pin = 1'h0;
    sgfc_frame_info_type i_frame = '0;
    sgfc_verdict_type o_verdict;
    logic i_an_tx_pause = 1'h1;
    logic i_an_rx_pause = 1'h1;
    logic o_tx_pause_en;
    logic o_rx_pause_en;
    logic [4:0] i_link_up = 5'h1F;
    logic [4:0] o_flush_ports;
    logic o_age_enable;
    logic o_age_tick;
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [7:0] d;

    always #12.5 i_ref_clk = ~i_ref_clk;

    // short aging periods keep the run brief
    sgfc_top #(.FAST_AGE_CYCLES(20), .NORMAL_AGE_CYCLES(50), .NUM_PORTS(5)) sgfc_top_inst (
        .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_mgmt_req(i_mgmt_req),
        .o_mgmt_rdata(o_mgmt_rdata), .o_mgmt_rvalid(o_mgmt_rvalid),
        .i_pause_strap_pin(i_pause_strap_pin), .i_aging_strap_pin(i_aging_strap_pin),
        .i_frame(i_frame), .o_verdict(o_verdict), .i_an_tx_pause(i_an_tx_pause),
        .i_an_rx_pause(i_an_rx_pause), .o_tx_pause_en(o_tx_pause_en),
        .o_rx_pause_en(o_rx_pause_en), .i_link_up(i_link_up), .o_flush_ports(o_flush_ports),
        .o_age_enable(o_age_enable), .o_age_tick(o_age_tick));

    sgfc_host_model sgfc_host_model_inst (.i_ref_clk(i_ref_clk), .i_rdata(o_mgmt_rdata),
        .i_rvalid(o_mgmt_rvalid), .o_req(i_mgmt_req));

    task automatic end_sim;
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one frame, verdict looked at in the cycle after it stands
    task automatic frm(input logic [47:0] da, input logic [15:0] tl, input logic [15:0] pl,
                       input logic fc, input logic bad, input logic drop);
        @(posedge i_ref_clk);
        i_frame <= '{1'h1, da, tl, pl, fc, bad};
        @(posedge i_ref_clk);
        i_frame <= '0;
        #1;
        `CHK("verdict", {1'h1, drop}, {o_verdict.valid, o_verdict.drop})
    endtask

    // cycles between two age ticks, waits bounded
    task automatic age_gap(input int ex);
        int n;
        n = 0;
        while (o_age_tick !== 1'h1 && n < 200) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end while (o_age_tick !== 1'h1 && n < 200);
        `CHK("age gap", ex, n)
    endtask

    // hang guard, well above the length of the sequence
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fail_count++;
            end_sim();
        end
    end

    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_resetn <= 1'h1;
        repeat (4) @(posedge i_ref_clk);
        sgfc_host_model_inst.read(SGFC_ADDR_GC_ONE, d);
        `CHK("gc1 strap", 8'h30, d)
        `CHK("pause en", 2'h0, {o_tx_pause_en, o_rx_pause_en})
        sgfc_host_model_inst.read(SGFC_ADDR_GC_ZERO, d);
        `CHK("gc0 reset", 8'h00, d)
        sgfc_host_model_inst.write(SGFC_ADDR_GC_ONE, 8'h24);
        `CHK("tx only off", 3'h3, {o_tx_pause_en, o_rx_pause_en, o_age_enable})
        age_gap(50);
        sgfc_host_model_inst.write(SGFC_ADDR_GC_ONE, 8'h16);
        `CHK("rx only off", 2'h2, {o_tx_pause_en, o_rx_pause_en})
        age_gap(20);
        sgfc_host_model_inst.write(SGFC_ADDR_GC_ONE, 8'h40);
        sgfc_host_model_inst.read(SGFC_ADDR_GC_ONE, d);
        `CHK("gc1 rsvd", 8'h40, d)
        `CHK("aging off", 1'h0, o_age_enable)
        // both disables clear: each enable now follows its autoneg result
        `CHK("an both on", 2'h3, {o_tx_pause_en, o_rx_pause_en})
        @(posedge i_ref_clk) {i_an_tx_pause, i_an_rx_pause} <= 2'h1;
        #1 `CHK("an tx off", 2'h1, {o_tx_pause_en, o_rx_pause_en})
        @(posedge i_ref_clk) {i_an_tx_pause, i_an_rx_pause} <= 2'h2;
        #1 `CHK("an rx off", 2'h2, {o_tx_pause_en, o_rx_pause_en})
        @(posedge i_ref_clk) {i_an_tx_pause, i_an_rx_pause} <= 2'h3;
        // unmapped place: write ignored, reads as zero
        sgfc_host_model_inst.write(8'h05, 8'hFF);
        sgfc_host_model_inst.read(8'h05, d);
        `CHK("unmapped", 8'h00, d)
        sgfc_host_model_inst.write(SGFC_ADDR_GC_ZERO, 8'hFF);
        sgfc_host_model_inst.read(SGFC_ADDR_GC_ZERO, d);
        `CHK("gc0 bits", 8'h03, d)
        sgfc_host_model_inst.write(SGFC_ADDR_GC_ZERO, 8'h00);
        frm(48'h0, SGFC_TYPE_MAC_CTRL, 16'h0, 1'h0, 1'h0, 1'h0);
        frm(48'h0, 16'h0800, 16'h0, 1'h1, 1'h0, 1'h1);
        sgfc_host_model_inst.write(SGFC_ADDR_GC_ZERO, 8'h02);
        frm(48'h0, SGFC_TYPE_MAC_CTRL, 16'h0, 1'h0, 1'h0, 1'h1);
        frm(SGFC_DA_PAUSE, 16'h0800, 16'h0, 1'h0, 1'h0, 1'h1);
        frm(48'h0, 16'h0800, 16'h0, 1'h1, 1'h0, 1'h0);
        frm(48'h0, 16'h0064, 16'h0063, 1'h0, 1'h0, 1'h0);
        sgfc_host_model_inst.write(SGFC_ADDR_GC_ONE, 8'h08);
        frm(48'h0, 16'h0064, 16'h0063, 1'h0, 1'h0, 1'h1);
        frm(48'h0, 16'h0064, 16'h0064, 1'h0, 1'h0, 1'h0);
        frm(48'h0, 16'h05DC, 16'h0001, 1'h0, 1'h0, 1'h0);
        frm(48'h0, 16'h0800, 16'h0, 1'h0, 1'h1, 1'h1);
        sgfc_host_model_inst.write(SGFC_ADDR_GC_ONE, 8'h88);
        frm(48'h0, 16'h0800, 16'h0, 1'h0, 1'h1, 1'h0);
        frm(48'h0, SGFC_TYPE_MAC_CTRL, 16'h0064, 1'h0, 1'h0, 1'h0);
        // link loss with fast aging off, then on
        @(posedge i_ref_clk) i_link_up <= 5'h1B;
        @(posedge i_ref_clk);
        #1 `CHK("no flush", 5'h00, o_flush_ports)
        sgfc_host_model_inst.write(SGFC_ADDR_GC_ZERO, 8'h03);
        @(posedge i_ref_clk) i_link_up <= 5'h13;
        @(posedge i_ref_clk);
        #1 `CHK("flush", 5'h08, o_flush_ports)
        end_sim();
    end
endmodule // tb_top
